//--- hdl/ncf_controller.sv
// Controller end: APB register front and flash bus sequencer.
// Assumes the target shares mclk and answers read strobes one cycle later.
//
// Local design decision: the APB interface to the registers.
module ncf_controller
	import ncf_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Flash bus
	ncf_flash_if.host bus,
	// Status
	output logic opBusy
);
	typedef enum logic [3:0] {
		HS_IDLE = 4'b0000,
		HS_CMD1 = 4'b0001,
		HS_ADR1 = 4'b0011,
		HS_ADR2 = 4'b0010,
		HS_CMD2 = 4'b0110,
		HS_WAIT = 4'b0111,
		HS_WRITE = 4'b0101,
		HS_READ = 4'b0100,
		HS_CAPT = 4'b1100
	} ncf_hstate_t;

	ncf_hstate_t state;
	ncf_op_t opCode;
	logic [7:0] featAddr;
	logic [15:0] colAddr;
	logic [31:0] params;
	logic [31:0] result;
	logic syncMode;
	logic start;
	logic [1:0] idx;
	logic dup;
	logic [15:0] waitCnt;
	logic waitRdy;
	logic apbWrite;
	logic [7:0] paramSel;
	logic [7:0] cmdFirst;

	assign apbWrite = psel & penable & pready & pwrite;
	assign paramSel = params[{idx, 3'b000} +: 8];

	always_comb begin
		case (opCode)
			OP_CHG_READ: cmdFirst = CMD_CHG_READ;
			OP_CHG_WRITE: cmdFirst = CMD_CHG_WRITE;
			OP_SET_FEATURE: cmdFirst = CMD_SET_FEATURE;
			OP_GET_FEATURE: cmdFirst = CMD_GET_FEATURE;
			OP_RESET: cmdFirst = CMD_RESET;
			default: cmdFirst = CMD_SYNC_RESET;
		endcase
	end

	// APB answer: one access cycle, error on unmapped offsets
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pready <= 1'b1;
			pslverr <= 1'b0;
			case (paddr)
				REG_CTRL: prdata <= {16'h0000, featAddr, 5'h00, opCode};
				REG_COLUMN: prdata <= {16'h0000, colAddr};
				REG_PARAM: prdata <= params;
				REG_STATUS: prdata <= {29'h00000000, bus.ready, syncMode, opBusy};
				REG_RESULT: prdata <= result;
				default: begin
					prdata <= 32'h00000000;
					pslverr <= 1'b1;
				end
			endcase
		end else begin
			pready <= 1'b0;
		end
	end

	// Order registers; frozen while an operation runs
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			opCode <= OP_CHG_READ;
			featAddr <= 8'h00;
			colAddr <= 16'h0000;
			params <= 32'h00000000;
			start <= 1'b0;
		end else begin
			start <= 1'b0;
			if (apbWrite && !opBusy && !start) begin
				case (paddr)
					REG_CTRL: begin
						if (pwdata[2:0] <= 3'h5) begin
							opCode <= ncf_op_t'(pwdata[2:0]);
							featAddr <= pwdata[15:8];
							start <= 1'b1;
						end
					end
					REG_COLUMN: colAddr <= pwdata[15:0];
					// Reserved parameter bits are sent as software wrote them
					REG_PARAM: params <= pwdata;
					default: start <= 1'b0;
				endcase
			end
		end
	end

	// Flash bus sequencer
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state <= HS_IDLE;
			bus.cle <= 1'b0;
			bus.ale <= 1'b0;
			bus.wrStrobe <= 1'b0;
			bus.rdStrobe <= 1'b0;
			bus.hostDq <= 16'h0000;
			bus.hostDqOe <= 1'b0;
			opBusy <= 1'b0;
			syncMode <= 1'b0;
			result <= 32'h00000000;
			idx <= 2'd0;
			dup <= 1'b0;
			waitCnt <= 16'h0000;
			waitRdy <= 1'b0;
		end else begin
			bus.cle <= 1'b0;
			bus.ale <= 1'b0;
			bus.wrStrobe <= 1'b0;
			bus.rdStrobe <= 1'b0;
			bus.hostDqOe <= 1'b0;
			case (state)
				HS_IDLE: begin
					opBusy <= start;
					if (start) begin
						bus.cle <= 1'b1;
						bus.wrStrobe <= 1'b1;
						bus.hostDq <= {8'h00, cmdFirst};
						bus.hostDqOe <= 1'b1;
						idx <= 2'd0;
						dup <= 1'b0;
						state <= HS_CMD1;
					end
				end
				HS_CMD1: begin
					if (opCode == OP_RESET || opCode == OP_SYNC_RESET) begin
						waitCnt <= 16'h0001;
						waitRdy <= 1'b1;
						state <= HS_WAIT;
					end else begin
						bus.ale <= 1'b1;
						bus.wrStrobe <= 1'b1;
						bus.hostDqOe <= 1'b1;
						if (opCode == OP_CHG_READ || opCode == OP_CHG_WRITE) begin
							bus.hostDq <= {8'h00, colAddr[7:0]};
							state <= HS_ADR1;
						end else begin
							bus.hostDq <= {8'h00, featAddr};
							state <= HS_ADR2;
						end
					end
				end
				HS_ADR1: begin
					bus.ale <= 1'b1;
					bus.wrStrobe <= 1'b1;
					bus.hostDq <= {8'h00, colAddr[15:8]};
					bus.hostDqOe <= 1'b1;
					state <= HS_ADR2;
				end
				HS_ADR2: begin
					waitRdy <= 1'b0;
					waitCnt <= COL_CHANGE_SETUP_CYC;
					state <= HS_WAIT;
					if (opCode == OP_CHG_READ) begin
						bus.cle <= 1'b1;
						bus.wrStrobe <= 1'b1;
						bus.hostDq <= {8'h00, CMD_CHG_READ_END};
						bus.hostDqOe <= 1'b1;
						state <= HS_CMD2;
					end else if (opCode == OP_SET_FEATURE) begin
						bus.wrStrobe <= 1'b1;
						bus.hostDq <= {8'h00, params[7:0]};
						bus.hostDqOe <= 1'b1;
						state <= HS_WRITE;
					end else if (opCode == OP_GET_FEATURE) begin
						waitCnt <= 16'h0001;
						waitRdy <= 1'b1;
					end
				end
				HS_CMD2: begin
					waitCnt <= COL_CHANGE_SETUP_CYC;
					state <= HS_WAIT;
				end
				HS_WAIT: begin
					if (waitCnt > 16'h0001) begin
						waitCnt <= waitCnt - 16'h0001;
					end else if (!waitRdy || bus.ready) begin
						// Status is never polled while busy; ready pin only
						state <= HS_IDLE;
						opBusy <= 1'b0;
						if (opCode == OP_RESET) begin
							syncMode <= 1'b0;
						end
						if (opCode == OP_CHG_READ || opCode == OP_GET_FEATURE) begin
							bus.rdStrobe <= 1'b1;
							opBusy <= 1'b1;
							state <= HS_READ;
						end else if (opCode == OP_CHG_WRITE) begin
							bus.wrStrobe <= 1'b1;
							bus.hostDq <= {8'h00, params[7:0]};
							bus.hostDqOe <= 1'b1;
							opBusy <= 1'b1;
							state <= HS_WRITE;
						end
					end
				end
				HS_WRITE: begin
					if (opCode == OP_SET_FEATURE && syncMode && !dup) begin
						dup <= 1'b1;
						bus.wrStrobe <= 1'b1;
						bus.hostDq <= {8'h00, paramSel};
						bus.hostDqOe <= 1'b1;
					end else if (opCode == OP_SET_FEATURE && idx != 2'd3) begin
						dup <= 1'b0;
						idx <= idx + 2'd1;
						bus.wrStrobe <= 1'b1;
						bus.hostDq <= {8'h00, params[{idx + 2'd1, 3'b000} +: 8]};
						bus.hostDqOe <= 1'b1;
					end else if (opCode == OP_SET_FEATURE) begin
						if (featAddr == FEAT_TIMING && params[TM_IF_LSB +: 2] == IF_SYNC) begin
							syncMode <= 1'b1;
						end
						waitCnt <= 16'h0001;
						waitRdy <= 1'b1;
						state <= HS_WAIT;
					end else begin
						state <= HS_IDLE;
						opBusy <= 1'b0;
					end
				end
				HS_READ: state <= HS_CAPT;
				HS_CAPT: begin
					if (opCode == OP_CHG_READ) begin
						result <= {24'h000000, bus.dq[7:0]};
						state <= HS_IDLE;
						opBusy <= 1'b0;
					end else begin
						if (!syncMode || !dup) begin
							result[{idx, 3'b000} +: 8] <= bus.dq[7:0];
						end
						if (syncMode && !dup) begin
							dup <= 1'b1;
							bus.rdStrobe <= 1'b1;
							state <= HS_READ;
						end else if (idx != 2'd3) begin
							dup <= 1'b0;
							idx <= idx + 2'd1;
							bus.rdStrobe <= 1'b1;
							state <= HS_READ;
						end else begin
							// All four bytes read before any other command
							state <= HS_IDLE;
							opBusy <= 1'b0;
						end
					end
				end
				default: state <= HS_IDLE;
			endcase
		end
	end
endmodule

//--- hdl/ncf_pkg.sv
// Shared constants for the column change and feature control ends.
// Assumes one clock (mclk, 50 ns) shared by both ends of the flash bus.
package ncf_pkg;

	// Clock and time figures, in ns
	localparam int CLK_PERIOD_NS = 50;
	localparam int COL_CHANGE_SETUP_NS = 100;
	localparam int FEATURE_BUSY_NS = 1000;
	localparam int TIMING_CHANGE_BUSY_NS = 5000;
	localparam int RESET_BUSY_NS = 50;

	// Least times round up to whole cycles
	localparam logic [15:0] COL_CHANGE_SETUP_CYC = 16'((COL_CHANGE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [15:0] FEATURE_BUSY_CYC = 16'((FEATURE_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [15:0] TIMING_CHANGE_BUSY_CYC = 16'((TIMING_CHANGE_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [15:0] RESET_BUSY_CYC = 16'((RESET_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Command codes
	localparam logic [7:0] CMD_CHG_READ = 8'h05;
	localparam logic [7:0] CMD_CHG_READ_END = 8'he0;
	localparam logic [7:0] CMD_CHG_WRITE = 8'h85;
	localparam logic [7:0] CMD_SET_FEATURE = 8'hef;
	localparam logic [7:0] CMD_GET_FEATURE = 8'hee;
	localparam logic [7:0] CMD_RESET = 8'hff;
	localparam logic [7:0] CMD_SYNC_RESET = 8'hfc;

	// Feature selector values
	localparam logic [7:0] FEAT_TIMING = 8'h01;
	localparam logic [7:0] FEAT_DRIVE = 8'h10;

	// Field layouts and power-on values
	localparam int TM_NUM_LSB = 0;
	localparam int TM_IF_LSB = 4;
	localparam int DRV_LSB = 0;
	localparam logic [1:0] IF_ASYNC = 2'h0;
	localparam logic [1:0] IF_SYNC = 2'h1;
	localparam logic [3:0] TIMING_MODE_RESET = 4'h0;
	localparam logic [1:0] DRIVE_OVERDRIVE2 = 2'h0;
	localparam logic [1:0] DRIVE_OVERDRIVE1 = 2'h1;
	localparam logic [1:0] DRIVE_NOMINAL = 2'h2;
	localparam logic [1:0] DRIVE_UNDERDRIVE = 2'h3;

	// Controller register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_COLUMN = 8'h04;
	localparam logic [7:0] REG_PARAM = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_RESULT = 8'h10;

	typedef enum logic [2:0] {
		OP_CHG_READ = 3'h0,
		OP_CHG_WRITE = 3'h1,
		OP_SET_FEATURE = 3'h2,
		OP_GET_FEATURE = 3'h3,
		OP_RESET = 3'h4,
		OP_SYNC_RESET = 3'h5
	} ncf_op_t;

endpackage

//--- hdl/ncf_flash_if.sv
// Flash bus between the controller and the target.
// Assumes both ends run on mclk; the shared data wire is resolved here.
interface ncf_flash_if;
	logic cle;
	logic ale;
	logic wrStrobe;
	logic rdStrobe;
	logic [15:0] hostDq;
	logic hostDqOe;
	logic [15:0] devDq;
	logic devDqOe;
	logic ready;
	logic [15:0] dq;

	// Undriven wire reads as zero
	assign dq = hostDqOe ? hostDq : (devDqOe ? devDq : 16'h0000);

	modport device(input cle, ale, wrStrobe, rdStrobe, dq, output devDq, devDqOe, ready);
	modport host(output cle, ale, wrStrobe, rdStrobe, hostDq, hostDqOe, input dq, ready);
endinterface

//--- hdl/ncf_target.sv
// Target end: column change, set and get feature handling with page register.
// Assumes the controller issues one bus cycle per mclk strobe on the same clock.
module ncf_target
	import ncf_pkg::*;
#(
	parameter int PAGE_BYTES = 256
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Flash bus
	ncf_flash_if.device bus,
	// Present settings
	output logic [3:0] timingMode,
	output logic [1:0] dataInterface,
	output logic [1:0] driveStrength,
	output logic [15:0] column
);
	localparam int PAGE_AW = $clog2(PAGE_BYTES);

	typedef enum logic [2:0] {
		SQ_IDLE = 3'b000,
		SQ_COLL = 3'b001,
		SQ_COLH = 3'b011,
		SQ_END = 3'b010,
		SQ_FA = 3'b110,
		SQ_PARM = 3'b111
	} ncf_seq_t;

	typedef enum logic [1:0] {
		DM_NONE = 2'b00,
		DM_READ = 2'b01,
		DM_WRITE = 2'b11,
		DM_GET = 2'b10
	} ncf_dmode_t;

	logic [7:0] page [PAGE_BYTES];
	ncf_seq_t seq;
	ncf_dmode_t dmode;
	logic isWriteCol;
	logic isGet;
	logic [7:0] colLow;
	logic [15:0] newCol;
	logic [7:0] featSel;
	logic [7:0] param1;
	logic [1:0] byteIdx;
	logic dupPhase;
	logic [15:0] busyCnt;
	logic [7:0] getByte;
	logic [7:0] dqLow;
	logic cmdCyc;
	logic addrCyc;
	logic dataIn;
	logic dataOut;
	logic syncMode;
	logic takeCopy;
	logic applyFeat;
	logic readEnd;
	logic isReset;

	assign dqLow = bus.dq[7:0];
	assign cmdCyc = bus.wrStrobe & bus.cle;
	assign addrCyc = bus.wrStrobe & bus.ale & ~bus.cle;
	assign dataIn = bus.wrStrobe & ~bus.cle & ~bus.ale;
	assign dataOut = bus.rdStrobe;
	assign syncMode = (dataInterface == IF_SYNC);
	// Second copy of a doubled byte is skipped
	assign takeCopy = ~syncMode | ~dupPhase;
	assign applyFeat = dataIn & (seq == SQ_PARM) & takeCopy & (byteIdx == 2'd3);
	assign readEnd = cmdCyc & (dqLow == CMD_CHG_READ_END) & (seq == SQ_END);
	assign isReset = cmdCyc & ((dqLow == CMD_RESET) | (dqLow == CMD_SYNC_RESET));

	// Command and address sequencing
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			seq <= SQ_IDLE;
			isWriteCol <= 1'b0;
			isGet <= 1'b0;
			colLow <= 8'h00;
			newCol <= 16'h0000;
			featSel <= 8'h00;
		end else if (cmdCyc) begin
			seq <= SQ_IDLE;
			case (dqLow)
				CMD_CHG_READ: begin
					seq <= SQ_COLL;
					isWriteCol <= 1'b0;
				end
				CMD_CHG_WRITE: begin
					seq <= SQ_COLL;
					isWriteCol <= 1'b1;
				end
				CMD_SET_FEATURE: begin
					seq <= SQ_FA;
					isGet <= 1'b0;
				end
				CMD_GET_FEATURE: begin
					seq <= SQ_FA;
					isGet <= 1'b1;
				end
				default: seq <= SQ_IDLE;
			endcase
		end else if (addrCyc) begin
			case (seq)
				SQ_COLL: begin
					colLow <= dqLow;
					seq <= SQ_COLH;
				end
				SQ_COLH: begin
					newCol <= {dqLow, colLow};
					seq <= isWriteCol ? SQ_IDLE : SQ_END;
				end
				SQ_FA: begin
					featSel <= dqLow;
					seq <= isGet ? SQ_IDLE : SQ_PARM;
				end
				default: seq <= SQ_IDLE;
			endcase
		end else if (applyFeat) begin
			seq <= SQ_IDLE;
		end
	end

	// Parameter byte index and copy phase
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			byteIdx <= 2'd0;
			dupPhase <= 1'b0;
		end else if (cmdCyc || (addrCyc && seq == SQ_FA)) begin
			byteIdx <= 2'd0;
			dupPhase <= 1'b0;
		end else if ((dataIn && seq == SQ_PARM) || (dataOut && dmode == DM_GET)) begin
			if (syncMode && !dupPhase) begin
				dupPhase <= 1'b1;
			end else begin
				dupPhase <= 1'b0;
				byteIdx <= byteIdx + 2'd1;
			end
		end
	end

	// Only the first parameter byte carries fields; the rest are reserved
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			param1 <= 8'h00;
		end else if (dataIn && seq == SQ_PARM && takeCopy && byteIdx == 2'd0) begin
			param1 <= dqLow;
		end
	end

	// Data direction after a completed sequence
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			dmode <= DM_NONE;
		end else if (readEnd) begin
			dmode <= DM_READ;
		end else if (cmdCyc) begin
			dmode <= DM_NONE;
		end else if (addrCyc && seq == SQ_COLH && isWriteCol) begin
			dmode <= DM_WRITE;
		end else if (addrCyc && seq == SQ_FA && isGet) begin
			dmode <= DM_GET;
		end
	end

	// Column pointer
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			column <= 16'h0000;
		end else if (readEnd) begin
			column <= newCol;
		end else if (addrCyc && seq == SQ_COLH && isWriteCol) begin
			column <= {dqLow, colLow};
		end else if ((dataIn && dmode == DM_WRITE) || (dataOut && dmode == DM_READ)) begin
			column <= column + 16'h0001;
		end
	end

	// Page register; writes past the end wrap
	always_ff @(posedge mclk) begin
		if (dataIn && dmode == DM_WRITE) begin
			page[column[PAGE_AW-1:0]] <= dqLow;
		end
	end

	// Present settings as read back
	always_comb begin
		getByte = 8'h00;
		if (byteIdx == 2'd0) begin
			case (featSel)
				FEAT_TIMING: getByte = {2'b00, dataInterface, timingMode};
				FEAT_DRIVE: getByte = {6'b000000, driveStrength};
				default: getByte = 8'h00;
			endcase
		end
	end

	// Output data, held after its read strobe
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			bus.devDq <= 16'h0000;
			bus.devDqOe <= 1'b0;
		end else if (dataOut && dmode == DM_READ) begin
			bus.devDq <= {8'h00, page[column[PAGE_AW-1:0]]};
			bus.devDqOe <= 1'b1;
		end else if (dataOut && dmode == DM_GET) begin
			bus.devDq <= {8'h00, getByte};
			bus.devDqOe <= 1'b1;
		end else begin
			bus.devDqOe <= 1'b0;
		end
	end

	// Feature settings; power-up restores all defaults, CMD_RESET restores the data interface only
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			timingMode <= TIMING_MODE_RESET;
			dataInterface <= IF_ASYNC;
			driveStrength <= DRIVE_NOMINAL;
		end else if (cmdCyc && dqLow == CMD_RESET) begin
			dataInterface <= IF_ASYNC;
		end else if (applyFeat) begin
			case (featSel)
				FEAT_TIMING: begin
					timingMode <= param1[TM_NUM_LSB +: 4];
					// Reserved interface codes leave the setting unchanged
					if (!param1[TM_IF_LSB + 1]) begin
						dataInterface <= param1[TM_IF_LSB +: 2];
					end
				end
				FEAT_DRIVE: driveStrength <= param1[DRV_LSB +: 2];
				default: timingMode <= timingMode;
			endcase
		end
	end

	// Ready/busy timer
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			bus.ready <= 1'b1;
			busyCnt <= 16'h0000;
		end else if (isReset) begin
			bus.ready <= 1'b0;
			busyCnt <= RESET_BUSY_CYC;
		end else if (applyFeat) begin
			bus.ready <= 1'b0;
			busyCnt <= (featSel == FEAT_TIMING) ? TIMING_CHANGE_BUSY_CYC : FEATURE_BUSY_CYC;
		end else if (addrCyc && seq == SQ_FA && isGet) begin
			bus.ready <= 1'b0;
			busyCnt <= FEATURE_BUSY_CYC;
		end else if (!bus.ready) begin
			busyCnt <= busyCnt - 16'h0001;
			if (busyCnt <= 16'h0001) begin
				bus.ready <= 1'b1;
			end
		end
	end
endmodule

//--- testbench/ncf_bus_asserts.sv
// Checker for the flash bus between controller and target.
// Assumes one clock domain; instantiated beside the interface.
module ncf_bus_asserts
	import ncf_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Flash bus
	input wire logic cle,
	input wire logic ale,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	input wire logic [15:0] hostDq,
	input wire logic hostDqOe,
	input wire logic [15:0] devDq,
	input wire logic devDqOe,
	input wire logic ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] lowCnt;
	logic [1:0] adrCnt;
	logic [7:0] lastCmd;
	logic [7:0] lastSel;

	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);

	// Busy length, judged when ready returns
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			lowCnt <= 16'h0000;
		else
			lowCnt <= ready ? 16'h0000 : lowCnt + 16'h0001;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			lastCmd <= 8'h00;
			lastSel <= 8'h00;
		end else if (wrStrobe && cle) begin
			lastCmd <= hostDq[7:0];
		end else if (wrStrobe && ale) begin
			lastSel <= hostDq[7:0];
		end
	end

	// Address cycles since the last command; tells the last column byte
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			adrCnt <= 2'd0;
		else if (wrStrobe && cle)
			adrCnt <= 2'd0;
		else if (wrStrobe && ale && adrCnt != 2'd3)
			adrCnt <= adrCnt + 2'd1;
	end

	property p_rd_answer;
		rdStrobe |=> devDqOe;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("no data after read strobe");
	property p_oe_cause;
		devDqOe |-> $past(rdStrobe) ##1 !devDqOe;
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("target drove data unasked");
	property p_low_lines;
		devDqOe |-> devDq[15:8] == 8'h00;
	endproperty
	a_low_lines: assert property (p_low_lines) else $error("upper data lines not zero");
	property p_ccs_read;
		wrStrobe && cle && hostDq[7:0] == CMD_CHG_READ_END |=> !rdStrobe [*2];
	endproperty
	a_ccs_read: assert property (p_ccs_read) else $error("read too soon after column change");
	property p_busy_cause;
		$fell(ready) |-> $past(wrStrobe);
	endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy without a taken cycle");
	property p_busy_itc;
		$rose(ready) && lastCmd == CMD_SET_FEATURE && lastSel == FEAT_TIMING |-> lowCnt == TIMING_CHANGE_BUSY_CYC;
	endproperty
	a_busy_itc: assert property (p_busy_itc) else $error("timing change busy length wrong");
	property p_busy_feat;
		$rose(ready) && (lastCmd == CMD_GET_FEATURE || (lastCmd == CMD_SET_FEATURE && lastSel != FEAT_TIMING))
			|-> lowCnt == FEATURE_BUSY_CYC;
	endproperty
	a_busy_feat: assert property (p_busy_feat) else $error("feature busy length wrong");
	property p_busy_reset;
		$rose(ready) && (lastCmd == CMD_RESET || lastCmd == CMD_SYNC_RESET) |-> lowCnt == RESET_BUSY_CYC;
	endproperty
	a_busy_reset: assert property (p_busy_reset) else $error("reset busy length wrong");
	property p_ccs_write;
		wrStrobe && ale && !cle && lastCmd == CMD_CHG_WRITE && adrCnt == 2'd1 |=> !wrStrobe [*2];
	endproperty
	a_ccs_write: assert property (p_ccs_write) else $error("write data too soon after column change");
	property p_chg_idle;
		wrStrobe && cle && hostDq[7:0] == CMD_CHG_READ |-> ready;
	endproperty
	a_chg_idle: assert property (p_chg_idle) else $error("column change while target busy");
endmodule

//--- testbench/ncf_control_test.sv
// Self-checking bench: controller and target joined by the flash bus.
// Assumes registers reached over APB and one 20 MHz clock.
module ncf_control_test
	import ncf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0;
	logic arst_n = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, opBusy;
	logic [3:0] timingMode;
	logic [1:0] dataInterface, driveStrength;
	logic [15:0] column;
	logic [31:0] rdata;
	logic err;
	int failures = 0;
	int num_checks = 0;

	always #25 mclk = ~mclk;

	ncf_flash_if fb();
	ncf_target ncf_target_i(.mclk(mclk), .arst_n(arst_n), .bus(fb.device), .timingMode(timingMode),
		.dataInterface(dataInterface), .driveStrength(driveStrength), .column(column));
	ncf_controller ncf_controller_i(.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus(fb.host), .opBusy(opBusy));
	ncf_bus_asserts ncf_bus_asserts_i(.mclk(mclk), .arst_n(arst_n), .cle(fb.cle), .ale(fb.ale),
		.wrStrobe(fb.wrStrobe), .rdStrobe(fb.rdStrobe), .hostDq(fb.hostDq), .hostDqOe(fb.hostDqOe),
		.devDq(fb.devDq), .devDqOe(fb.devDqOe), .ready(fb.ready));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Idle cycle after each transfer keeps one assignment per time step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			failures++;
			$display("[FAIL] %0t no bus answer", $time);
		end
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic run(input logic [2:0] op, input logic [7:0] sel, input logic [31:0] p);
		int n = 0;
		apb(1'b1, REG_PARAM, p);
		apb(1'b1, REG_CTRL, {16'h0000, sel, 5'h00, op});
		repeat (3) @(posedge mclk);
		do begin
			apb(1'b0, REG_STATUS, 32'h0);
			n++;
		end while (rdata[0] !== 1'b0 && n < 400);
		check({31'h0, n < 400}, 32'h1);
	endtask

	task automatic get_feat(input logic [7:0] sel);
		run(OP_GET_FEATURE, sel, 32'h0);
		apb(1'b0, REG_RESULT, 32'h0);
	endtask

	task automatic col_op(input logic [2:0] op, input logic [15:0] col, input logic [7:0] d);
		apb(1'b1, REG_COLUMN, {16'h0000, col});
		run(op, 8'h00, {24'h0, d});
		apb(1'b0, REG_RESULT, 32'h0);
	endtask

	task automatic wrap_up();
		if (failures == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		#2000000;
		failures++;
		$display("[FAIL] %0t watchdog expired", $time);
		wrap_up();
	end

	initial begin
		// Falling edge at time zero so the asynchronous reset really fires
		arst_n <= 1'b0;
		repeat (8) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		check({26'h0, dataInterface, timingMode}, 32'h0);
		check({30'h0, driveStrength}, {30'h0, DRIVE_NOMINAL});
		get_feat(FEAT_DRIVE);
		check(rdata & 32'h3, {30'h0, DRIVE_NOMINAL});
		apb(1'b0, 8'h14, 32'h0);
		check({31'h0, err}, 32'h1);
		// Reserved bits set on purpose: the target must not care
		for (int d = 0; d < 4; d++) begin
			run(OP_SET_FEATURE, FEAT_DRIVE, {24'hffffff, 6'h3f, 2'(d)});
			check({30'h0, driveStrength}, 32'(d));
			get_feat(FEAT_DRIVE);
			check(rdata, 32'(d));
		end
		run(OP_SET_FEATURE, 8'h80, 32'h1);
		check({26'h0, dataInterface, timingMode}, 32'h0);
		check({30'h0, driveStrength}, 32'h3);
		get_feat(8'h02);
		check(rdata, 32'h0);
		run(OP_SET_FEATURE, FEAT_TIMING, 32'h13);
		check({26'h0, dataInterface, timingMode}, 32'h13);
		check(rdata, 32'h6);
		get_feat(FEAT_TIMING);
		check(rdata, 32'h13);
		run(OP_SET_FEATURE, FEAT_DRIVE, 32'h1);
		check({30'h0, driveStrength}, 32'h1);
		run(OP_SYNC_RESET, 8'h00, 32'h0);
		check({26'h0, dataInterface, timingMode}, 32'h13);
		check({30'h0, driveStrength}, 32'h1);
		run(OP_RESET, 8'h00, 32'h0);
		check(rdata, 32'h4);
		check({26'h0, dataInterface, timingMode}, 32'h03);
		check({30'h0, driveStrength}, 32'h1);
		run(OP_SET_FEATURE, FEAT_TIMING, 32'h20);
		check({30'h0, dataInterface}, {30'h0, IF_ASYNC});
		check({26'h0, dataInterface, timingMode}, 32'h0);
		col_op(OP_CHG_WRITE, 16'h0042, 8'ha5);
		check({16'h0, column}, 32'h43);
		col_op(OP_CHG_WRITE, 16'h0001, 8'h5a);
		// Wraps onto byte 42h only if the low byte goes first
		col_op(OP_CHG_READ, 16'h0142, 8'h00);
		check(rdata & 32'hff, 32'ha5);
		check({16'h0, column}, 32'h143);
		col_op(OP_CHG_READ, 16'h0001, 8'h00);
		check(rdata & 32'hff, 32'h5a);
		wrap_up();
	end
endmodule
